// ---- hw/exd_pkg.sv ----
// Summary of operation
// RL1 - extended opcodes stay inactive after reset unless the extension fuse reads set
// RL2 - standard opcodes pass through; eight extra literal opcodes decode when enabled
// RL3 - pointer add/subtract with select field 11 works on pointer two and returns
// RL4 - add 6-bit literal to selected pointer 0..2, one cycle, flags untouched
// RL5 - add literal to pointer two then load pc from stack top, two cycles
// RL6 - call through working register, two cycles, flags untouched
// RL7 - move indexed source byte to absolute 12-bit address from second word
// RL8 - move indexed source byte to indexed destination from second word, flags untouched
// RL9 - store 8-bit literal at pointer two then decrement pointer two, one cycle
// RL10 - subtract 6-bit literal from selected pointer, one cycle, flags untouched
// RL11 - add-and-return adds the 6-bit literal to pointer two, then returns
// RL12 - auto-return opcodes: pointer update first cycle, no-operation second cycle
// RL13 - subtract literal from pointer two then return through stack top, two cycles
// RL14 - with fuse clear, no pointer, pc or stack side effect for these opcodes
package exd_pkg;
  // opcode high bytes and fixed codes
  localparam logic [7:0] EXD_OP_ADD = 8'hE8;
  localparam logic [7:0] EXD_OP_SUB = 8'hE9;
  localparam logic [7:0] EXD_OP_PUSH = 8'hEA;
  localparam logic [7:0] EXD_OP_MOVS = 8'hEB;
  localparam logic [15:0] EXD_OP_CALL_VIA_WORKING_REGISTER = 16'h0014;
  localparam logic [3:0] EXD_WORD2_TAG = 4'hF;
  localparam logic [1:0] EXD_FSEL_RET = 2'h3;
  // field positions, widths and reset values
  localparam int EXD_MOVS_MODE_BIT = 7;
  localparam int EXD_PTR_W = 12;
  localparam int EXD_PC_W = 21;
  localparam logic [11:0] EXD_PTR_RST = 12'h000;
  localparam logic [20:0] EXD_PC_RST = 21'h000000;
  localparam logic [7:0] EXD_DATA_RST = 8'h00;

  typedef enum logic [4:0] {
    EXD_ST_IDLE = 5'h01,
    EXD_ST_RD = 5'h02,
    EXD_ST_MV2 = 5'h04,
    EXD_ST_RET2 = 5'h08,
    EXD_ST_CALL2 = 5'h10
  } exd_st_t;

  typedef struct packed {
    exd_st_t st;
    logic taken;
    logic en;
    logic [2:0][11:0] ptr;
    logic [7:0] data;
    logic [11:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_re;
    logic mem_we;
    logic pc_load;
    logic pc_push;
    logic [20:0] pc_target;
    logic nop_slot;
    logic ext_hit;
    logic mode;
  } exd_state_t;

  localparam exd_state_t EXD_RST = '{
    st: EXD_ST_IDLE, taken: 1'b0, en: 1'b0, ptr: {3{EXD_PTR_RST}}, data: EXD_DATA_RST,
    mem_addr: EXD_PTR_RST, mem_wdata: EXD_DATA_RST, mem_re: 1'b0, mem_we: 1'b0,
    pc_load: 1'b0, pc_push: 1'b0, pc_target: EXD_PC_RST, nop_slot: 1'b0, ext_hit: 1'b0, mode: 1'b0};
endpackage

// ---- hw/exd_decoder.sv ----
`timescale 1ns/1ns
module exd_decoder (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_fuse,
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [7:0] i_working_register,
  input wire logic [12:0] i_pclat,
  input wire logic [20:0] i_tos,
  input wire logic [7:0] i_mem_rdata,
  output logic [11:0] o_ptr0,
  output logic [11:0] o_ptr1,
  output logic [11:0] o_ptr2,
  output logic o_mem_re,
  output logic o_mem_we,
  output logic [11:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_pc_load,
  output logic o_pc_push,
  output logic [20:0] o_pc_target,
  output logic o_nop_slot,
  output logic o_ext_hit,
  output logic o_enabled
);
  // ***************************************************************
  // decode helpers
  // ***************************************************************
  exd_pkg::exd_state_t q, d;
  logic [7:0] op;
  logic [1:0] fsel;
  logic [11:0] k6;
  logic [11:0] idx_src;
  logic [11:0] idx_dst;
  logic word2;
  logic [7:0] move_byte;

  assign op = i_instr[15:8];
  assign fsel = i_instr[7:6];
  assign k6 = {6'h00, i_instr[5:0]};
  assign idx_src = q.ptr[2] + {5'h00, i_instr[6:0]};
  assign idx_dst = q.ptr[2] + {5'h00, i_instr[6:0]};
  assign word2 = i_instr_valid && (i_instr[15:12] == exd_pkg::EXD_WORD2_TAG);
  // read data is only on the bus in the same cycle as the read strobe
  assign move_byte = (q.st == exd_pkg::EXD_ST_RD) ? i_mem_rdata : q.data;

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    d = q;
    d.mem_re = 1'b0;
    d.mem_we = 1'b0;
    d.pc_load = 1'b0;
    d.pc_push = 1'b0;
    d.nop_slot = 1'b0;
    d.ext_hit = 1'b0;
    // fuse is caught once after reset release, never under the reset itself
    if (!q.taken) begin
      d.taken = 1'b1;
      d.en = i_fuse; // see RL1
    end
    unique case (q.st)
      exd_pkg::EXD_ST_IDLE: begin
        // fuse clear: nothing is claimed, standard decoder keeps the word
        if (i_instr_valid && q.en) begin // see RL14 see RL2
          if (op == exd_pkg::EXD_OP_ADD || op == exd_pkg::EXD_OP_SUB) begin
            d.ext_hit = 1'b1;
            if (fsel == exd_pkg::EXD_FSEL_RET) begin // see RL3
              if (op == exd_pkg::EXD_OP_ADD) begin
                d.ptr[2] = q.ptr[2] + k6; // see RL5 see RL11
              end else begin
                d.ptr[2] = q.ptr[2] - k6; // see RL13
              end
              d.pc_load = 1'b1;
              d.pc_target = i_tos;
              d.st = exd_pkg::EXD_ST_RET2; // see RL12
            end else if (op == exd_pkg::EXD_OP_ADD) begin
              d.ptr[fsel] = q.ptr[fsel] + k6; // see RL4
            end else begin
              d.ptr[fsel] = q.ptr[fsel] - k6; // see RL10
            end
          end else if (op == exd_pkg::EXD_OP_PUSH) begin
            d.ext_hit = 1'b1;
            d.mem_we = 1'b1; // see RL9
            d.mem_addr = q.ptr[2];
            d.mem_wdata = i_instr[7:0];
            d.ptr[2] = q.ptr[2] - 12'h001;
          end else if (op == exd_pkg::EXD_OP_MOVS) begin
            d.ext_hit = 1'b1;
            d.mem_re = 1'b1; // see RL7 see RL8
            d.mem_addr = idx_src;
            d.mode = i_instr[exd_pkg::EXD_MOVS_MODE_BIT]; // kept apart so the read byte cannot overwrite it
            d.st = exd_pkg::EXD_ST_RD;
          end else if (i_instr == exd_pkg::EXD_OP_CALL_VIA_WORKING_REGISTER) begin
            d.ext_hit = 1'b1;
            d.pc_load = 1'b1; // see RL6
            d.pc_push = 1'b1;
            d.pc_target = {i_pclat, i_working_register};
            d.st = exd_pkg::EXD_ST_CALL2;
          end
        end
      end
      exd_pkg::EXD_ST_RD, exd_pkg::EXD_ST_MV2: begin
        // hold the read byte in case the second word is late
        if (q.st == exd_pkg::EXD_ST_RD) begin
          d.data = i_mem_rdata;
        end
        d.st = exd_pkg::EXD_ST_MV2;
        if (word2) begin
          d.ext_hit = 1'b1;
          d.mem_we = 1'b1;
          d.mem_wdata = move_byte;
          d.mem_addr = q.mode ? idx_dst : i_instr[11:0]; // see RL7 see RL8
          d.st = exd_pkg::EXD_ST_IDLE;
        end else if (i_instr_valid) begin
          // a first word not followed by a second word is dropped
          d.st = exd_pkg::EXD_ST_IDLE;
        end
      end
      exd_pkg::EXD_ST_RET2, exd_pkg::EXD_ST_CALL2: begin
        d.nop_slot = 1'b1; // see RL12
        d.st = exd_pkg::EXD_ST_IDLE;
      end
      default: d.st = exd_pkg::EXD_ST_IDLE;
    endcase
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= exd_pkg::EXD_RST;
    end else if (i_ce) begin
      q <= d;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  // any valid first word offered while the decoder is free and live
  logic ext_issue;
  assign ext_issue = q.en && (q.st == exd_pkg::EXD_ST_IDLE) && i_instr_valid;

  // return forms: stack top loaded at once, filler slot in the next cycle
  sequence ret_tail_s;
    q.pc_load && !q.pc_push && q.pc_target == $past(i_tos) ##1 q.nop_slot && !q.pc_load;
  endsequence

  // call: pushed and loaded at once, filler slot in the next cycle
  sequence call_tail_s;
    q.pc_load && q.pc_push && q.pc_target == {$past(i_pclat), $past(i_working_register)} ##1 q.nop_slot && !q.pc_push;
  endsequence

  // the fuse is only looked at once reset has gone
  fuse_wait_a: assert property ( // see RL1
    @(posedge i_clk) disable iff (!i_resetn || !i_ce)
    !q.taken |-> !q.en)
    else $error("extension live before the fuse was taken");

  // a fuse change in mid-run must not switch the set on or off
  fuse_hold_a: assert property ( // see RL1
    @(posedge i_clk) disable iff (!i_resetn || !i_ce)
    q.taken |=> $stable(q.en))
    else $error("extension enable moved without reset");

  // with the set off nothing may touch pointers, pc, stack or memory
  fuse_quiet_a: assert property ( // see RL14
    @(posedge i_clk) disable iff (!i_resetn || !i_ce)
    !q.en |=> !q.pc_load && !q.pc_push && !q.mem_we && !q.mem_re && !q.ext_hit && $stable(q.ptr))
    else $error("side effect with extension off");

  ptr_add_a: assert property ( // see RL4
    @(posedge i_clk) disable iff (!i_resetn || !i_ce)
    ext_issue && op == exd_pkg::EXD_OP_ADD && fsel == 2'h0
    |=> q.ptr[0] == $past(q.ptr[0]) + $past(k6))
    else $error("pointer add result wrong");

  ptr_sub_a: assert property ( // see RL10
    @(posedge i_clk) disable iff (!i_resetn || !i_ce)
    ext_issue && op == exd_pkg::EXD_OP_SUB && fsel == 2'h1
    |=> q.ptr[1] == $past(q.ptr[1]) - $past(k6))
    else $error("pointer subtract result wrong");

  ret_slot_a: assert property ( // see RL12
    @(posedge i_clk) disable iff (!i_resetn || !i_ce)
    ext_issue && (op == exd_pkg::EXD_OP_ADD || op == exd_pkg::EXD_OP_SUB) && fsel == exd_pkg::EXD_FSEL_RET
    |=> ret_tail_s)
    else $error("return form did not load and idle");

  call_slot_a: assert property ( // see RL6
    @(posedge i_clk) disable iff (!i_resetn || !i_ce)
    ext_issue && i_instr == exd_pkg::EXD_OP_CALL_VIA_WORKING_REGISTER
    |=> call_tail_s)
    else $error("call through working register wrong");

  push_store_a: assert property ( // see RL9
    @(posedge i_clk) disable iff (!i_resetn || !i_ce)
    ext_issue && op == exd_pkg::EXD_OP_PUSH
    |=> q.mem_we && q.mem_wdata == $past(i_instr[7:0]) && q.mem_addr == $past(q.ptr[2])
        && q.ptr[2] == $past(q.ptr[2]) - 12'h001)
    else $error("literal store or decrement wrong");

  // source offset counts from pointer two
  move_read_a: assert property ( // see RL7
    @(posedge i_clk) disable iff (!i_resetn || !i_ce)
    ext_issue && op == exd_pkg::EXD_OP_MOVS
    |=> q.mem_re && q.mem_addr == $past(q.ptr[2]) + {5'h00, $past(i_instr[6:0])})
    else $error("move source read wrong");

  move_abs_a: assert property ( // see RL7
    @(posedge i_clk) disable iff (!i_resetn || !i_ce)
    q.st == exd_pkg::EXD_ST_RD && word2 && !q.mode
    |=> q.mem_we && q.mem_wdata == $past(i_mem_rdata) && q.mem_addr == $past(i_instr[11:0]))
    else $error("absolute move write wrong");

  move_idx_a: assert property ( // see RL8
    @(posedge i_clk) disable iff (!i_resetn || !i_ce)
    q.st == exd_pkg::EXD_ST_RD && word2 && q.mode
    |=> q.mem_we && q.mem_wdata == $past(i_mem_rdata)
        && q.mem_addr == $past(q.ptr[2]) + {5'h00, $past(i_instr[6:0])})
    else $error("indexed move write wrong");

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign o_ptr0 = q.ptr[0];
  assign o_ptr1 = q.ptr[1];
  assign o_ptr2 = q.ptr[2];
  assign o_mem_re = q.mem_re;
  assign o_mem_we = q.mem_we;
  assign o_mem_addr = q.mem_addr;
  assign o_mem_wdata = q.mem_wdata;
  assign o_pc_load = q.pc_load;
  assign o_pc_push = q.pc_push;
  assign o_pc_target = q.pc_target;
  assign o_nop_slot = q.nop_slot;
  assign o_ext_hit = q.ext_hit;
  assign o_enabled = q.en;
endmodule // exd_decoder

// ---- tb/exd_tb.sv ----
`timescale 1ns/1ns
module tb;
  // ****************
  // signals
  // ****************
  logic i_clk, i_resetn, i_fuse, i_instr_valid;
  logic [15:0] i_instr;
  logic [20:0] o_pc_target, got_tgt;
  logic [11:0] o_ptr0, o_ptr1, o_ptr2, o_mem_addr, got_addr;
  logic [7:0] o_mem_wdata, got_wd;
  logic o_mem_re, o_mem_we, o_pc_load, o_pc_push, o_nop_slot, o_ext_hit, o_enabled;
  logic saw_load, saw_push, saw_we;
  logic saw_re, saw_hit, saw_nop;
  logic [11:0] got_raddr;
  int err_total, n_compared, cyc;
  // stack top, latch and working register are fixed so targets are easy to predict
  exd_decoder uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(1'b1), .i_fuse(i_fuse), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_working_register(8'h5A), .i_pclat(13'h0123), .i_tos(21'h0ABCDE), .i_mem_rdata(8'h3C),
    .o_ptr0(o_ptr0), .o_ptr1(o_ptr1), .o_ptr2(o_ptr2), .o_mem_re(o_mem_re), .o_mem_we(o_mem_we),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_pc_load(o_pc_load), .o_pc_push(o_pc_push),
    .o_pc_target(o_pc_target), .o_nop_slot(o_nop_slot), .o_ext_hit(o_ext_hit), .o_enabled(o_enabled));
  // ****************
  // helpers
  // ****************
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic do_reset(input logic f);
    i_resetn = 1'b0;
    i_fuse = f;
    repeat (5) @(posedge i_clk);
    #1 i_resetn = 1'b1;
  endtask
  // six cycles of watching after the last word; pulses may land in either slot
  task automatic watch;
    saw_load = 1'b0;
    saw_push = 1'b0;
    saw_we = 1'b0;
    saw_hit = 1'b0;
    saw_nop = 1'b0;
    repeat (6) begin
      @(posedge i_clk);
      #1 i_instr_valid = 1'b0;
      if (o_pc_load === 1'b1) begin saw_load = 1'b1; got_tgt = o_pc_target; end
      if (o_pc_push === 1'b1) begin saw_push = 1'b1; got_tgt = o_pc_target; end
      if (o_mem_we === 1'b1) begin saw_we = 1'b1; got_addr = o_mem_addr; got_wd = o_mem_wdata; end
      if (o_ext_hit === 1'b1) saw_hit = 1'b1;
      if (o_nop_slot === 1'b1) saw_nop = 1'b1;
    end
  endtask
  // one-cycle request
  task automatic exec(input logic [15:0] op);
    @(posedge i_clk);
    #1 i_instr = op;
    i_instr_valid = 1'b1;
    watch();
  endtask
  // two words on back-to-back edges; the source read shows between them
  task automatic exec2(input logic [15:0] w1, input logic [15:0] w2);
    @(posedge i_clk);
    #1 i_instr = w1;
    i_instr_valid = 1'b1;
    @(posedge i_clk);
    #1 i_instr = w2;
    saw_re = o_mem_re;
    got_raddr = o_mem_addr;
    watch();
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_fuse_clear;
    do_reset(1'b0);
    exec(16'hE83F);
    chk(o_ptr0 === 12'h000, "pointer moved with fuse clear");
    chk(o_enabled === 1'b0 && !saw_hit, "extension live with fuse clear");
    exec(16'hE8C5);
    chk(!saw_load && o_ptr2 === 12'h000, "return with fuse clear");
    exec(16'h0014);
    chk(!saw_push, "call with fuse clear");
  endtask
  task automatic t_add_sub;
    do_reset(1'b1);
    exec(16'hE83F);
    chk(o_ptr0 === 12'h03F && !saw_load, "add ptr0");
    chk(o_enabled === 1'b1 && saw_hit, "extension idle with fuse set");
    exec(16'hE841);
    chk(o_ptr1 === 12'h001, "add ptr1");
    exec(16'hE8A3);
    chk(o_ptr2 === 12'h023, "add ptr2");
    exec(16'hE901);
    chk(o_ptr0 === 12'h03E, "sub ptr0");
    exec(16'hE97F);
    chk(o_ptr1 === 12'hFC2, "sub ptr1 wrap");
  endtask
  task automatic t_ret;
    exec(16'hE8C5);
    chk(o_ptr2 === 12'h028 && saw_load && got_tgt === 21'h0ABCDE, "add and return");
    chk(saw_nop && !saw_push, "no filler cycle after return");
    exec(16'hE9C8);
    chk(o_ptr2 === 12'h020 && saw_load && got_tgt === 21'h0ABCDE, "sub and return");
  endtask
  task automatic t_push;
    exec(16'hEA55);
    chk(saw_we && got_addr === 12'h020 && got_wd === 8'h55, "push store");
    chk(o_ptr2 === 12'h01F, "push decrement");
  endtask
  task automatic t_call;
    exec(16'h0014);
    chk(saw_push && saw_nop && got_tgt === {13'h0123, 8'h5A}, "call via w");
    exec(16'h0F12);
    chk(!saw_hit && !saw_load && !saw_we && o_ptr2 === 12'h01F, "standard opcode claimed");
  endtask
  // source offsets count from pointer two, which the push left at 01F
  task automatic t_move;
    exec2(16'hEB05, 16'hF234);
    chk(saw_re === 1'b1 && got_raddr === 12'h024, "absolute move read");
    chk(saw_we && got_addr === 12'h234 && got_wd === 8'h3C, "absolute move write");
    exec2(16'hEB83, 16'hF007);
    chk(saw_re === 1'b1 && got_raddr === 12'h022, "indexed move read");
    chk(saw_we && got_addr === 12'h026 && got_wd === 8'h3C && o_ptr2 === 12'h01F, "indexed move write");
  endtask
  // ****************
  // clock, watchdog, main
  // ****************
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // cut a hang short well past the expected run length
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    i_resetn = 1'b0;
    i_fuse = 1'b0;
    i_instr_valid = 1'b0;
    i_instr = 16'h0000;
    t_fuse_clear();
    t_add_sub();
    t_ret();
    t_push();
    t_move();
    t_call();
    conclude();
  end
endmodule // tb
